// ===== rtl/msq_defines.svh
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define MSQ_STEP3_IDX   8'h93
`define MSQ_STEP4_IDX   8'h94

// Reset values.
`define MSQ_STEP3_RST   16'h0003
`define MSQ_STEP4_RST   16'h0004

// Field positions.
`define MSQ_EN_BIT      15
`define MSQ_GAIN_HI     14
`define MSQ_GAIN_LO     13
`define MSQ_RSV_HI      12
`define MSQ_RSV_LO      5
`define MSQ_NEG_BIT     4
`define MSQ_POS_HI      3
`define MSQ_POS_LO      0

// Positive codes at or above this value select internal sources.
`define MSQ_POS_INTERNAL 4'h8

// AXI responses.
`define MSQ_RESP_OKAY   2'h0
`define MSQ_RESP_SLVERR 2'h2

`endif

// ===== rtl/msq_pkg.sv
package msq_pkg;

  // One step configuration, as software programs it.
  typedef struct packed {
    logic       en;
    logic [1:0] gain;
    logic       neg;
    logic [3:0] pos;
  } msq_step_s;

  // Conversion request handed to the converter datapath.
  typedef struct packed {
    logic       stepFour;
    logic [2:0] gainFactor;
    logic [3:0] pos;
    logic       negExtSeven;
    logic       negAuto;
  } msq_conv_s;

  typedef enum logic [1:0] {
    MSQ_SEQ_IDLE,
    MSQ_SEQ_STEP3,
    MSQ_SEQ_STEP4
  } msq_seq_e;

endpackage

// ===== rtl/msq_step_cfg.sv
`timescale 1ns/1ns
`include "msq_defines.svh"

module msq_step_cfg #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Sequencer
  input  wire logic                seqAdvance,
  output logic                     convReq,
  output msq_pkg::msq_conv_s       convSel
);

  localparam logic [ADDR_W-1:0] ADDR3 =
    ADDR_W'({`MSQ_STEP3_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR4 =
    ADDR_W'({`MSQ_STEP4_IDX, 2'b00});

  msq_pkg::msq_step_s step3_r, step3_nxt, step4_r, step4_nxt;
  logic              awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0]       wData_r, wData_nxt;
  logic [3:0]        wStrb_r, wStrb_nxt;
  logic              awReady_r, awReady_nxt, wReady_r, wReady_nxt;
  logic              bValid_r, bValid_nxt;
  logic [1:0]        bResp_r, bResp_nxt;
  logic              arReady_r, arReady_nxt, rValid_r, rValid_nxt;
  logic [31:0]       rData_r, rData_nxt;
  logic [1:0]        rResp_r, rResp_nxt;
  msq_pkg::msq_seq_e seq_r, seq_nxt;
  logic              convReq_r, convReq_nxt;
  msq_pkg::msq_conv_s conv_r, conv_nxt;

  function automatic logic [15:0] packStep(msq_pkg::msq_step_s s);
    return {s.en, s.gain, 8'h00, s.neg, s.pos};
  endfunction

  // Only the documented fields take data; byte lanes follow wstrb.
  function automatic msq_pkg::msq_step_s writeStep(
    msq_pkg::msq_step_s s, logic [31:0] d, logic [3:0] strb);
    msq_pkg::msq_step_s r;
    r = s;
    if (strb[1]) begin
      r.en   = d[`MSQ_EN_BIT];
      r.gain = d[`MSQ_GAIN_HI:`MSQ_GAIN_LO];
    end
    if (strb[0]) begin
      r.neg = d[`MSQ_NEG_BIT];
      r.pos = d[`MSQ_POS_HI:`MSQ_POS_LO];
    end
    return r;
  endfunction

  function automatic msq_pkg::msq_conv_s buildConv(
    msq_pkg::msq_step_s s, logic four);
    msq_pkg::msq_conv_s c;
    c.stepFour = four;
    case (s.gain)
      2'h0:    c.gainFactor = 3'h1;
      2'h1:    c.gainFactor = 3'h2;
      default: c.gainFactor = 3'h4;
    endcase
    c.pos = s.pos;
    c.negAuto = (s.pos >= `MSQ_POS_INTERNAL);
    c.negExtSeven = s.neg & ~c.negAuto;
    return c;
  endfunction

  // Register bus next state.
  always_comb begin
    step3_nxt  = step3_r;
    step4_nxt  = step4_r;
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt  = wHeld_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (s_axi_awvalid && awReady_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (awHeld_r && wHeld_r && !bValid_r) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = `MSQ_RESP_OKAY;
      if (awAddr_r == ADDR3) begin
        step3_nxt = writeStep(step3_r, wData_r, wStrb_r);
      end else if (awAddr_r == ADDR4) begin
        step4_nxt = writeStep(step4_r, wData_r, wStrb_r);
      end else begin
        bResp_nxt = `MSQ_RESP_SLVERR;
      end
    end
    if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arReady_r) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = `MSQ_RESP_OKAY;
      if (s_axi_araddr == ADDR3) begin
        rData_nxt = {16'h0000, packStep(step3_r)};
      end else if (s_axi_araddr == ADDR4) begin
        rData_nxt = {16'h0000, packStep(step4_r)};
      end else begin
        rData_nxt = 32'h0000_0000;
        rResp_nxt = `MSQ_RESP_SLVERR;
      end
    end
    // A channel is refused while its previous item is still pending.
    awReady_nxt = !awHeld_nxt && !bValid_nxt;
    wReady_nxt  = !wHeld_nxt && !bValid_nxt;
    arReady_nxt = !rValid_nxt;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      step3_r   <= writeStep('0, {16'h0000, `MSQ_STEP3_RST}, 4'h3);
      step4_r   <= writeStep('0, {16'h0000, `MSQ_STEP4_RST}, 4'h3);
      awHeld_r  <= 1'b0;
      awAddr_r  <= '0;
      wHeld_r   <= 1'b0;
      wData_r   <= 32'h0000_0000;
      wStrb_r   <= 4'h0;
      awReady_r <= 1'b0;
      wReady_r  <= 1'b0;
      bValid_r  <= 1'b0;
      bResp_r   <= 2'h0;
      arReady_r <= 1'b0;
      rValid_r  <= 1'b0;
      rData_r   <= 32'h0000_0000;
      rResp_r   <= 2'h0;
    end else begin
      step3_r   <= step3_nxt;
      step4_r   <= step4_nxt;
      awHeld_r  <= awHeld_nxt;
      awAddr_r  <= awAddr_nxt;
      wHeld_r   <= wHeld_nxt;
      wData_r   <= wData_nxt;
      wStrb_r   <= wStrb_nxt;
      awReady_r <= awReady_nxt;
      wReady_r  <= wReady_nxt;
      bValid_r  <= bValid_nxt;
      bResp_r   <= bResp_nxt;
      arReady_r <= arReady_nxt;
      rValid_r  <= rValid_nxt;
      rData_r   <= rData_nxt;
      rResp_r   <= rResp_nxt;
    end
  end

  // Sequencer: steps take turns; a disabled step is passed over.
  always_comb begin
    seq_nxt     = seq_r;
    convReq_nxt = 1'b0;
    conv_nxt    = conv_r;
    if (seqAdvance) begin
      case (seq_r)
        msq_pkg::MSQ_SEQ_STEP3: begin
          if (step4_r.en) begin
            seq_nxt = msq_pkg::MSQ_SEQ_STEP4;
          end else if (step3_r.en) begin
            seq_nxt = msq_pkg::MSQ_SEQ_STEP3;
          end else begin
            seq_nxt = msq_pkg::MSQ_SEQ_IDLE;
          end
        end
        default: begin
          if (step3_r.en) begin
            seq_nxt = msq_pkg::MSQ_SEQ_STEP3;
          end else if (step4_r.en) begin
            seq_nxt = msq_pkg::MSQ_SEQ_STEP4;
          end else begin
            seq_nxt = msq_pkg::MSQ_SEQ_IDLE;
          end
        end
      endcase
      convReq_nxt = (seq_nxt != msq_pkg::MSQ_SEQ_IDLE);
      if (seq_nxt == msq_pkg::MSQ_SEQ_STEP4) begin
        conv_nxt = buildConv(step4_r, 1'b1);
      end else if (seq_nxt == msq_pkg::MSQ_SEQ_STEP3) begin
        conv_nxt = buildConv(step3_r, 1'b0);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_r     <= msq_pkg::MSQ_SEQ_IDLE;
      convReq_r <= 1'b0;
      conv_r    <= '0;
    end else begin
      seq_r     <= seq_nxt;
      convReq_r <= convReq_nxt;
      conv_r    <= conv_nxt;
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign convReq       = convReq_r;
  assign convSel       = conv_r;

  AST_RESERVED_ZERO: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rValid_r |-> rData_r[31:`MSQ_RSV_LO] ==
      {16'h0000, rData_r[15:13], 8'h00})
    else $error("Reserved read bits are not zero.");
  AST_STEP3_RESET: assert property (
    @(posedge mclk) $past(sys_rst) |-> packStep(step3_r) == `MSQ_STEP3_RST)
    else $error("Step three register did not reset to its value.");
  AST_STEP4_RESET: assert property (
    @(posedge mclk) $past(sys_rst) |-> packStep(step4_r) == `MSQ_STEP4_RST)
    else $error("Step four register did not reset to its value.");
  AST_SKIP_DISABLED: assert property (
    @(posedge mclk) disable iff (sys_rst)
    seqAdvance && !step3_r.en && !step4_r.en |=> !convReq_r)
    else $error("Conversion requested with no step enabled.");
  AST_ENABLED_CONVERTS: assert property (
    @(posedge mclk) disable iff (sys_rst)
    seqAdvance && (step3_r.en || step4_r.en) |=> convReq_r &&
      (conv_r.stepFour ? $past(step4_r.en) : $past(step3_r.en)))
    else $error("Enabled step was not converted.");
  // Step three is picked again after itself when step four is disabled.
  AST_GAIN_DECODE: assert property (
    @(posedge mclk) disable iff (sys_rst)
    seqAdvance && step3_r.en &&
      (seq_r != msq_pkg::MSQ_SEQ_STEP3 || !step4_r.en) |=>
      conv_r.gainFactor == ($past(step3_r.gain) == 2'h0 ? 3'h1 :
        $past(step3_r.gain) == 2'h1 ? 3'h2 : 3'h4))
    else $error("Gain factor does not match the gain code.");
  AST_NEG_AUTO: assert property (
    @(posedge mclk) disable iff (sys_rst)
    convReq_r |-> conv_r.negAuto == conv_r.pos[3] &&
      !(conv_r.negAuto && conv_r.negExtSeven))
    else $error("Negative input not chosen automatically.");
  AST_WRITE_RESPONSE: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_axi_awvalid && awReady_r && s_axi_wvalid && wReady_r &&
      s_axi_awaddr == ADDR3 |-> ##2 bValid_r && bResp_r == 2'h0
      ##0 step3_r == writeStep($past(step3_r, 2), $past(s_axi_wdata, 2),
        $past(s_axi_wstrb, 2)))
    else $error("Write to step three not applied two cycles on.");

endmodule

// ===== testbench/msq_step_cfg_tb.sv
`timescale 1ns/1ns
`include "msq_defines.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nFail++; \
  $display("[ERR] %0t act=%h exp=%h", $time, (a), (b)); end end

module testbench;
  localparam logic [11:0] A3 = {2'h0, `MSQ_STEP3_IDX, 2'h0};
  localparam logic [11:0] A4 = {2'h0, `MSQ_STEP4_IDX, 2'h0};
  logic               mclk;
  logic               sys_rst;
  logic [11:0]        awAddr;
  logic [11:0]        arAddr;
  logic [31:0]        wData;
  logic [3:0]         wStrb;
  logic [31:0]        rData;
  logic [1:0]         bResp;
  logic [1:0]         rResp;
  logic               awValid, awReady, wValid, wReady, bValid, bReady;
  logic               arValid, arReady, rValid, rReady, seqAdv, convReq;
  msq_pkg::msq_conv_s convSel;
  int                 nFail, totalChecks, cycles;

  msq_step_cfg #(.ADDR_W(12)) u_msq_step_cfg (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .seqAdvance(seqAdv),
    .convReq(convReq), .convSel(convSel)
  );

  always #5 mclk = ~mclk;

  // A hang anywhere ends the run here rather than stalling the simulator.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (nFail == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er, input logic [3:0] s = 4'hf);
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    // Waits as long as the answer takes; only the cycle ceiling ends a hang.
    do begin
      @(posedge mclk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
    `CHK(bResp, er)
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid);
    rReady <= 1'b0;
    `CHK(rData, ed)
    `CHK(rResp, er)
  endtask

  function automatic msq_pkg::msq_conv_s expc(input logic s4,
    input logic [1:0] g, input logic n, input logic [3:0] p);
    expc.stepFour = s4;
    expc.gainFactor = (g == 2'h0) ? 3'h1 : (g == 2'h1) ? 3'h2 : 3'h4;
    expc.pos = p;
    expc.negAuto = p >= `MSQ_POS_INTERNAL;
    expc.negExtSeven = expc.negAuto ? 1'b0 : n;
  endfunction

  task automatic adv(input logic req, input msq_pkg::msq_conv_s e);
    @(posedge mclk);
    seqAdv <= 1'b1;
    @(posedge mclk);
    seqAdv <= 1'b0;
    #1;
    `CHK(convReq, req)
    if (req) `CHK(convSel, e)
    @(posedge mclk);
    #1;
    `CHK(convReq, 1'b0)
  endtask

  task automatic t_reset;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    axi_rd(A3, 32'h0000_0003, `MSQ_RESP_OKAY);
    axi_rd(A4, 32'h0000_0004, `MSQ_RESP_OKAY);
  endtask

  task automatic t_unmapped;
    axi_wr(A3 - 12'h004, 32'h0000_ffff, `MSQ_RESP_SLVERR);
    axi_rd(A3 - 12'h004, 32'h0, `MSQ_RESP_SLVERR);
    axi_wr(A4 + 12'h004, 32'h0000_ffff, `MSQ_RESP_SLVERR);
    axi_rd(A3, 32'h0000_0003, `MSQ_RESP_OKAY);
    axi_rd(A4, 32'h0000_0004, `MSQ_RESP_OKAY);
  endtask

  // Every positive code once, with reserved bits set on each write.
  task automatic t_fields;
    logic [15:0] v;
    for (int k = 0; k < 16; k++) begin
      v = {1'b1, 2'(k), 8'h00, ~k[0], 4'(k)};
      axi_wr(A3, {16'h0000, v | 16'h1fe0}, `MSQ_RESP_OKAY);
      axi_rd(A3, {16'h0000, v}, `MSQ_RESP_OKAY);
      adv(1'b1, expc(1'b0, 2'(k), ~k[0], 4'(k)));
    end
  endtask

  task automatic t_step4;
    axi_wr(A3, 32'h0000_0003, `MSQ_RESP_OKAY);
    axi_wr(A4, 32'h0000_d017, `MSQ_RESP_OKAY);
    adv(1'b1, expc(1'b1, 2'h2, 1'b1, 4'h7));
    adv(1'b1, expc(1'b1, 2'h2, 1'b1, 4'h7));
  endtask

  task automatic t_none;
    axi_wr(A4, 32'h0000_0004, `MSQ_RESP_OKAY);
    adv(1'b0, expc(1'b0, 2'h0, 1'b0, 4'h0));
  endtask

  task automatic t_alternate;
    t_reset();
    axi_wr(A3, 32'h0000_8003, `MSQ_RESP_OKAY);
    axi_wr(A4, 32'h0000_a014, `MSQ_RESP_OKAY);
    adv(1'b1, expc(1'b0, 2'h0, 1'b0, 4'h3));
    adv(1'b1, expc(1'b1, 2'h1, 1'b1, 4'h4));
    adv(1'b1, expc(1'b0, 2'h0, 1'b0, 4'h3));
    // Each byte lane alone touches only its own fields.
    axi_wr(A4, 32'h0000_ffff, `MSQ_RESP_OKAY, 4'h1);
    axi_rd(A4, 32'h0000_a01f, `MSQ_RESP_OKAY);
    axi_wr(A4, 32'h0000_0000, `MSQ_RESP_OKAY, 4'h2);
    axi_rd(A4, 32'h0000_001f, `MSQ_RESP_OKAY);
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {awAddr, arAddr, wData} = '0;
    wStrb = 4'hf;
    {awValid, wValid, bReady, arValid, rReady, seqAdv} = '0;
    nFail = 0;
    totalChecks = 0;
    cycles = 0;
    t_reset();
    t_unmapped();
    t_fields();
    t_step4();
    t_none();
    t_alternate();
    finish_test();
  end
endmodule
